/* File: verilog/sup_pkg.sv */
`default_nettype none
package sup_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  // least times round up, typical/longest times round down
  function automatic int ns_to_cyc_up(input int ns);
    ns_to_cyc_up = (ns * CYC_PER_US + 999) / 1000;
  endfunction : ns_to_cyc_up

  function automatic int ns_to_cyc_dn(input int ns);
    ns_to_cyc_dn = (ns * CYC_PER_US) / 1000;
  endfunction : ns_to_cyc_dn

  localparam int WAKE_WAIT_NS = 10_000;
  localparam int WAKE_WAIT_CYC = ns_to_cyc_up(WAKE_WAIT_NS);
  localparam int STANDBY_DELAY_NS = 256_000;
  localparam int STANDBY_DELAY_CYC = ns_to_cyc_dn(STANDBY_DELAY_NS);
  localparam int CSN_HIGH_NS = 4_000;
  localparam int CSN_HIGH_CYC = ns_to_cyc_up(CSN_HIGH_NS);
  localparam int LINK_PERIOD_NS = 1_000;
  localparam int LINK_HALF_CYC = (ns_to_cyc_up(LINK_PERIOD_NS) + 1) / 2;
  localparam int HOST_CNT_W = 8;
  localparam int STBY_CNT_W = 12;

  localparam int FRAME_BITS = 24;
  localparam int FRAME_CNT_W = 5;
  localparam int OUT_N = 7;

  typedef enum logic [1:0] {
    CMD_WRITE = 2'b00,
    CMD_READ_CLEAR = 2'b01,
    CMD_SOFT_RESET = 2'b10,
    CMD_NOP = 2'b11
  } cmd_e;
  localparam int CMD_LSB = 22;

  // control word fields, frame bits [16:0]
  localparam int CTL_W = 17;
  localparam int CTL_EN = 0;
  localparam int CTL_RD = 1;
  localparam int CTL_OUT_LSB = 2;
  localparam int CTL_OCR_LSB = 9;
  localparam int CTL_MD = 16;

  // reply status fields
  localparam int ST_PUMP = 0;
  localparam int ST_TW = 1;
  localparam int ST_TSD = 2;
  localparam int ST_OV = 3;
  localparam int ST_UV = 4;
  localparam int ST_OC_LSB = 5;
  localparam int ST_OL_LSB = 12;
  localparam int ST_ACTIVE = 19;

  typedef enum logic [1:0] {
    GATE_NORMAL = 2'b00,
    GATE_RES_LOW = 2'b01,
    GATE_SINK = 2'b10
  } gate_e;

  localparam int AXI_ADDR_W = 4;
  localparam logic [AXI_ADDR_W-1:0] REG_CMD = 4'h0;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_ADDR_W-1:0] REG_REPLY = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STAT_BUSY = 0;
endpackage : sup_pkg
`default_nettype wire

/* File: verilog/sup_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sup_link_if;
  logic chip_sel_n;
  logic link_clk;
  logic host_data;
  logic dev_data;
  logic dev_data_oe;
  logic dev_data_line;

  // released line is pulled high
  assign dev_data_line = dev_data_oe ? dev_data : 1'b1;

  modport host (
    output chip_sel_n,
    output link_clk,
    output host_data,
    input dev_data_line
  );

  modport dev (
    input chip_sel_n,
    input link_clk,
    input host_data,
    output dev_data,
    output dev_data_oe
  );
endinterface : sup_link_if
`default_nettype wire

/* File: verilog/sup_device.sv */
// Notes on behaviour
// [R1] after power-up, sit in standby, analog off
// [R2] chip select low wakes device to active
// [R3] host waits 10 us before first transfer
// [R4] no enable: standby 256 us after select rises
// [R5] host should switch outputs off before standby
// [R6] shifted data applied only at select rising
// [R7] logic state survives power supply glitches
// [R8] pump off in standby and after thermal shutdown
// [R9] filtered pump-low: flag, outputs off, gates low
// [R10] pump-low stop held until software reset or supply recovery
// [R11] status bits set only after filter time
// [R12] open load and warning only set status
// [R13] overcurrent stops one driver, shutdown stops all
// [R14] no recovery bit: off until status cleared
// [R15] overvoltage: outputs hiz, pump off, gates sink
// [R16] undervoltage: output stages to high impedance
// [R17] supply back: pump on, flag cleared, restore
// [R18] recovery disabled: host must clear status bits
// [R19] host should set supply recovery disable bit
// [R20] power-on reset initialises the logic
// [R21] logic supply low: tri-state, clear status
// [R22] logic supply high: hold reset until it falls
// [R23] warning and shutdown latched until read-clear
// [R24] comparator inputs synchronised, each own filter except the logic supply ones
`timescale 1ns/1ps
`default_nettype none
module sup_device #(
  parameter int FILTER_CYC = 16,
  parameter int FILTER_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  sup_link_if.dev lk,
  input wire logic vs_over,
  input wire logic vs_under,
  input wire logic pump_low_in,
  input wire logic temp_warn_in,
  input wire logic temp_shut_in,
  input wire logic [sup_pkg::OUT_N-1:0] oc_in,
  input wire logic [sup_pkg::OUT_N-1:0] ol_in,
  input wire logic vcc_low_in,
  input wire logic vcc_high_in,
  output logic [sup_pkg::OUT_N-1:0] drive_on,
  output logic [sup_pkg::OUT_N-1:0] drive_hiz,
  output logic pump_enable,
  output logic mirror_dimming_control,
  output sup_pkg::gate_e gate_mode,
  output logic analog_active
);
  import sup_pkg::*;

  localparam int NF = 5 + 2 * OUT_N;
  localparam int NR = NF + 2;
  localparam int I_OV = 0;
  localparam int I_UV = 1;
  localparam int I_PUMP = 2;
  localparam int I_TW = 3;
  localparam int I_TSD = 4;
  localparam int I_OC = 5;
  localparam int I_OL = 5 + OUT_N;
  localparam logic [FILTER_W-1:0] FILT_MAX = FILTER_W'(FILTER_CYC);
  localparam logic [STBY_CNT_W-1:0] STBY_LAST = STBY_CNT_W'(STANDBY_DELAY_CYC - 1);
  localparam logic [FRAME_CNT_W-1:0] FRAME_N = FRAME_CNT_W'(FRAME_BITS);

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_ACTIVE_MODE = 2'b01,
    ST_RESET_HOLD = 2'b10
  } dev_state_e;

  typedef struct packed {
    logic [2:0] lk1;
    logic [2:0] lk2;
    logic [NR-1:0] an1;
    logic [NR-1:0] an2;
    logic [NF-1:0][FILTER_W-1:0] fcnt;
    logic prev_clk;
    logic prev_csn;
    dev_state_e st;
    logic [STBY_CNT_W-1:0] stby_cnt;
    logic [FRAME_BITS-1:0] shin;
    logic [FRAME_BITS-1:0] shout;
    logic [FRAME_CNT_W-1:0] nbits;
    logic [CTL_W-1:0] ctrl;
    logic pump_flag;
    logic tw;
    logic tsd;
    logic ov;
    logic uv;
    logic [OUT_N-1:0] oc;
    logic [OUT_N-1:0] ol;
    logic sup_fault_d;
    logic miso_oe;
    logic [OUT_N-1:0] drive;
    logic [OUT_N-1:0] hiz;
    logic pump_en;
    logic mdc;
    gate_e gate;
    logic act;
  } dev_s;

  dev_s r;
  dev_s n;

  function automatic logic [FRAME_BITS-1:0] status_word(input dev_s s);
    status_word = '0;
    status_word[ST_PUMP] = s.pump_flag;
    status_word[ST_TW] = s.tw;
    status_word[ST_TSD] = s.tsd;
    status_word[ST_OV] = s.ov;
    status_word[ST_UV] = s.uv;
    status_word[ST_OC_LSB +: OUT_N] = s.oc;
    status_word[ST_OL_LSB +: OUT_N] = s.ol;
    status_word[ST_ACTIVE] = (s.st == ST_ACTIVE_MODE);
  endfunction : status_word

  always_comb
  begin
    logic [NF-1:0] fok;
    logic csn;
    logic sclk;
    logic mosi;
    logic active;
    logic csn_fall;
    logic csn_rise;
    logic clk_rise;
    logic clk_fall;
    logic frame_ok;
    logic clr_rc;
    logic clr_sr;
    logic sup_now;
    logic sup_recover;
    logic sup_off;
    logic ov_off;
    logic all_off;
    logic vcc_low;
    logic vcc_high;
    logic [OUT_N-1:0] oc_rec;
    logic [OUT_N-1:0] oc_off;
    fok = '0;
    n = r;
    // first stages feed only the second stages
    n.lk1 = {lk.chip_sel_n, lk.link_clk, lk.host_data};
    n.lk2 = r.lk1;
    n.an1 = {vcc_high_in, vcc_low_in, ol_in, oc_in, temp_shut_in, temp_warn_in, pump_low_in, vs_under, vs_over};
    n.an2 = r.an1;
    for (int i = 0; i < NF; i++)
    begin
      fok[i] = r.an2[i] && (r.fcnt[i] == FILT_MAX); // [R11] [R24]
      if (!r.an2[i])
        n.fcnt[i] = '0;
      else if (r.fcnt[i] != FILT_MAX)
        n.fcnt[i] = r.fcnt[i] + 1'b1;
    end
    vcc_low = r.an2[NF];
    vcc_high = r.an2[NF+1];
    csn = r.lk2[2];
    sclk = r.lk2[1];
    mosi = r.lk2[0];
    n.prev_clk = sclk;
    n.prev_csn = csn;
    active = (r.st == ST_ACTIVE_MODE);
    csn_fall = r.prev_csn && !csn;
    csn_rise = !r.prev_csn && csn;
    clk_rise = !r.prev_clk && sclk && !csn;
    clk_fall = r.prev_clk && !sclk && !csn;
    frame_ok = csn_rise && (r.nbits == FRAME_N);
    clr_rc = frame_ok && (cmd_e'(r.shin[CMD_LSB +: 2]) == CMD_READ_CLEAR);
    clr_sr = frame_ok && (cmd_e'(r.shin[CMD_LSB +: 2]) == CMD_SOFT_RESET);

    // serial shifting
    if (csn_fall)
    begin
      n.nbits = '0;
      n.shout = status_word(r);
      if (r.st == ST_STANDBY)
        n.st = ST_ACTIVE_MODE; // [R2]
    end
    if (clk_rise)
    begin
      n.shin = {r.shin[FRAME_BITS-2:0], mosi};
      if (r.nbits != FRAME_N)
        n.nbits = r.nbits + 1'b1;
    end
    if (clk_fall)
      n.shout = {r.shout[FRAME_BITS-2:0], 1'b0};
    n.miso_oe = !csn;
    // outputs see new data only here, never mid-frame
    if (frame_ok && (cmd_e'(r.shin[CMD_LSB +: 2]) == CMD_WRITE))
      n.ctrl = r.shin[CTL_W-1:0]; // [R6]
    if (clr_sr)
      n.ctrl = '0;

    // status latches: a new set outweighs a clear in the same cycle
    sup_now = fok[I_OV] || fok[I_UV];
    sup_recover = r.sup_fault_d && !sup_now && !r.ctrl[CTL_RD];
    n.sup_fault_d = sup_now;
    n.pump_flag = (active && fok[I_PUMP]) || (r.pump_flag && !clr_sr && !sup_recover); // [R9] [R10] [R17]
    n.tw = (active && fok[I_TW]) || (r.tw && !clr_rc); // [R23]
    n.tsd = (active && fok[I_TSD]) || (r.tsd && !clr_rc); // [R23]
    n.ov = (active && fok[I_OV]) || (r.ov && !clr_rc);
    n.uv = (active && fok[I_UV]) || (r.uv && !clr_rc);
    n.oc = ({OUT_N{active}} & fok[I_OC +: OUT_N]) | (r.oc & ~{OUT_N{clr_rc}}); // [R14]
    // open load is watched on switched-on stages and only reported
    n.ol = (r.drive & fok[I_OL +: OUT_N]) | (r.ol & ~{OUT_N{clr_rc}}); // [R12]

    // standby fallback once select has risen without the enable bit
    if (active && csn && !r.ctrl[CTL_EN])
    begin
      n.stby_cnt = r.stby_cnt + 1'b1;
      if (r.stby_cnt == STBY_LAST)
      begin
        n.st = ST_STANDBY; // [R4]
        n.ctrl = '0;
        n.pump_flag = 1'b0;
        n.tw = 1'b0;
        n.tsd = 1'b0;
        n.ov = 1'b0;
        n.uv = 1'b0;
        n.oc = '0;
        n.ol = '0;
      end
    end
    else
      n.stby_cnt = '0;

    // logic supply window; the power supply never touches this state [R7]
    if (vcc_low || vcc_high)
    begin
      n.st = ST_RESET_HOLD; // [R21] [R22]
      n.ctrl = '0;
      n.pump_flag = 1'b0;
      n.tw = 1'b0;
      n.tsd = 1'b0;
      n.ov = 1'b0;
      n.uv = 1'b0;
      n.oc = '0;
      n.ol = '0;
      n.stby_cnt = '0;
    end
    else if (r.st == ST_RESET_HOLD)
      n.st = ST_STANDBY; // [R22] [R1]

    // output stage control
    ov_off = fok[I_OV] || (r.ctrl[CTL_RD] && r.ov);
    sup_off = sup_now || (r.ctrl[CTL_RD] && (r.ov || r.uv)); // [R17] [R18]
    oc_rec = r.ctrl[CTL_OCR_LSB +: OUT_N];
    // with recovery set the driver only pauses while the fault is present
    oc_off = (r.oc & ~oc_rec) | fok[I_OC +: OUT_N]; // [R13] [R14]
    all_off = !active || r.tsd || r.pump_flag || sup_off; // [R9] [R13]
    n.drive = r.ctrl[CTL_OUT_LSB +: OUT_N] & ~oc_off & ~{OUT_N{all_off}};
    n.hiz = {OUT_N{vcc_low || (active && sup_off)}}; // [R15] [R16] [R21]
    if (vcc_low)
      n.drive = '0;
    n.pump_en = active && !r.tsd && !ov_off; // [R8] [R15]
    if (active && ov_off)
      n.gate = GATE_SINK; // [R15]
    else if (!active || r.tsd || r.pump_flag)
      n.gate = GATE_RES_LOW; // [R9]
    else
      n.gate = GATE_NORMAL;
    n.mdc = active && r.ctrl[CTL_MD] && !r.pump_flag && !r.tsd && !sup_off; // [R9]
    n.act = active;
  end

  // aresetn is the power-on reset of the logic supply
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0; // [R20] [R1]
      // idle levels: select high, link clock low, so no false edge after reset
      r.lk1 <= 3'h4;
      r.lk2 <= 3'h4;
      r.prev_csn <= 1'b1;
      r.gate <= GATE_RES_LOW;
    end
    else
      r <= n;
  end

  assign lk.dev_data = r.shout[FRAME_BITS-1];
  assign lk.dev_data_oe = r.miso_oe;
  assign drive_on = r.drive;
  assign drive_hiz = r.hiz;
  assign pump_enable = r.pump_en;
  assign mirror_dimming_control = r.mdc;
  assign gate_mode = r.gate;
  assign analog_active = r.act;
endmodule : sup_device
`default_nettype wire

/* File: verilog/sup_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sup_host (
  input wire logic aclk,
  input wire logic aresetn,
  sup_link_if.host lk,
  input wire logic [sup_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sup_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sup_pkg::*;

  localparam logic [HOST_CNT_W-1:0] WAKE_LAST = HOST_CNT_W'(WAKE_WAIT_CYC - 1);
  localparam logic [HOST_CNT_W-1:0] HALF_LAST = HOST_CNT_W'(LINK_HALF_CYC - 1);
  localparam logic [HOST_CNT_W-1:0] GAP_LAST = HOST_CNT_W'(CSN_HIGH_CYC - 1);
  localparam logic [FRAME_CNT_W-1:0] LAST_BIT = FRAME_CNT_W'(FRAME_BITS - 1);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_WAKE = 3'b001,
    H_LOW = 3'b010,
    H_HIGH = 3'b011,
    H_TAIL = 3'b100,
    H_GAP = 3'b101
  } host_e;

  typedef struct packed {
    host_e st;
    logic [HOST_CNT_W-1:0] cnt;
    logic [FRAME_CNT_W-1:0] bitn;
    logic [FRAME_BITS-1:0] frame;
    logic [FRAME_BITS-1:0] tx;
    logic [FRAME_BITS-1:0] rx;
    logic [FRAME_BITS-1:0] reply;
    logic csn;
    logic sclk;
    logic mosi;
    logic miso1;
    logic miso2;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } host_s;

  host_s r;
  host_s n;

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      merge_strb[8*b +: 8] = be[b] ? wd[8*b +: 8] : old[8*b +: 8];
  endfunction : merge_strb

  always_comb
  begin
    logic start;
    logic [31:0] merged;
    n = r;
    start = 1'b0;
    n.miso1 = lk.dev_data_line;
    n.miso2 = r.miso1;
    merged = merge_strb({8'h00, r.frame}, r.wdata, r.wstrb);

    // write channel: address and data taken in either order
    if (s_axi_awvalid && r.awready)
    begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wready)
    begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
      n.wready = 1'b0;
    end
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_SLVERR;
      // a frame cannot be replaced while it is on the wire
      if (r.awaddr == REG_CMD && r.st == H_IDLE)
      begin
        n.frame = merged[FRAME_BITS-1:0];
        n.bresp = RESP_OKAY;
        start = 1'b1;
      end
    end
    if (r.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end

    // read channel
    if (s_axi_arvalid && r.arready)
    begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      if (s_axi_araddr == REG_CMD)
        n.rdata[FRAME_BITS-1:0] = r.frame;
      else if (s_axi_araddr == REG_STATUS)
        n.rdata[STAT_BUSY] = (r.st != H_IDLE);
      else if (s_axi_araddr == REG_REPLY)
        n.rdata[FRAME_BITS-1:0] = r.reply;
      else
        n.rresp = RESP_SLVERR;
    end
    if (r.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // link sequencer; link clock is divided down from aclk
    n.cnt = r.cnt + 1'b1;
    case (r.st)
      H_IDLE:
      begin
        n.cnt = '0;
        if (start)
        begin
          n.tx = merged[FRAME_BITS-1:0];
          n.csn = 1'b0; // [R2]
          n.st = H_WAKE;
        end
      end
      H_WAKE:
        if (r.cnt == WAKE_LAST)
        begin
          n.cnt = '0;
          n.bitn = '0;
          n.mosi = r.tx[FRAME_BITS-1];
          n.st = H_LOW; // [R3]
        end
      H_LOW:
        if (r.cnt == HALF_LAST)
        begin
          n.cnt = '0;
          n.sclk = 1'b1;
          n.st = H_HIGH;
        end
      H_HIGH:
        if (r.cnt == HALF_LAST)
        begin
          n.cnt = '0;
          n.sclk = 1'b0;
          // sampled before the device reacts to this falling edge
          n.rx = {r.rx[FRAME_BITS-2:0], r.miso2};
          n.tx = {r.tx[FRAME_BITS-2:0], 1'b0};
          n.mosi = r.tx[FRAME_BITS-2];
          n.bitn = r.bitn + 1'b1;
          n.st = (r.bitn == LAST_BIT) ? H_TAIL : H_LOW;
        end
      H_TAIL:
        if (r.cnt == HALF_LAST)
        begin
          n.cnt = '0;
          n.csn = 1'b1; // [R6]
          n.mosi = 1'b0;
          n.reply = r.rx;
          n.st = H_GAP;
        end
      H_GAP:
        if (r.cnt == GAP_LAST)
          n.st = H_IDLE;
      default:
        n.st = H_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
      r.csn <= 1'b1;
      r.miso1 <= 1'b1;
      r.miso2 <= 1'b1;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end
    else
      r <= n;
  end

  assign lk.chip_sel_n = r.csn;
  assign lk.link_clk = r.sclk;
  assign lk.host_data = r.mosi;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bresp = r.bresp;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_arready = r.arready;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rvalid = r.rvalid;
endmodule : sup_host
`default_nettype wire

/* File: bench/sup_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sup_checker #(
  parameter int FILTER_CYC = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_sel_n,
  input wire logic link_clk,
  input wire logic vs_over,
  input wire logic vs_under,
  input wire logic pump_low_in,
  input wire logic temp_shut_in,
  input wire logic vcc_low_in,
  input wire logic vcc_high_in,
  input wire logic [sup_pkg::OUT_N-1:0] drive_on,
  input wire logic [sup_pkg::OUT_N-1:0] drive_hiz,
  input wire logic pump_enable,
  input wire logic mirror_dimming_control,
  input wire sup_pkg::gate_e gate_mode,
  input wire logic analog_active
);
  import sup_pkg::*;
  // sync chain, filter, latch and output flop all fit inside this margin
  localparam int HOLD = FILTER_CYC + 8;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [6:0] cond;
  logic [7:0] cnt [7];
  assign cond = {!chip_sel_n, vs_over, vs_under, pump_low_in, temp_shut_in, vcc_low_in, vcc_high_in};
  // saturating run lengths of each condition
  always_ff @(posedge aclk)
  begin
    for (int n = 0; n < 7; n++)
    begin
      if (!aresetn || !cond[n])
        cnt[n] <= 8'h00;
      else if (cnt[n] != 8'hff)
        cnt[n] <= cnt[n] + 8'h01;
    end
  end
  property p_wake;
    $fell(chip_sel_n) && !analog_active |-> ##[1:8] analog_active;
  endproperty
  a_wake: assert property (p_wake)
    else $error("select low did not wake");
  property p_wait;
    $rose(link_clk) |-> int'(cnt[6]) >= WAKE_WAIT_CYC;
  endproperty
  a_wait: assert property (p_wait)
    else $error("link clock too soon after select");
  property p_stby;
    !analog_active [*3] |-> !pump_enable;
  endproperty
  a_stby: assert property (p_stby)
    else $error("pump on in standby");
  property p_tsd;
    int'(cnt[2]) >= HOLD |-> !pump_enable && drive_on == '0;
  endproperty
  a_tsd: assert property (p_tsd)
    else $error("drivers or pump on after shutdown");
  property p_ov;
    analog_active && int'(cnt[5]) >= HOLD |-> &drive_hiz && !pump_enable && gate_mode == GATE_SINK;
  endproperty
  a_ov: assert property (p_ov)
    else $error("overvoltage not handled");
  property p_uv;
    analog_active && int'(cnt[4]) >= HOLD |-> &drive_hiz;
  endproperty
  a_uv: assert property (p_uv)
    else $error("undervoltage outputs not high impedance");
  property p_plow;
    analog_active && int'(cnt[3]) >= HOLD |->
      drive_on == '0 && !mirror_dimming_control && gate_mode == GATE_RES_LOW;
  endproperty
  a_plow: assert property (p_plow)
    else $error("pump low not handled");
  property p_vlow;
    int'(cnt[1]) >= 6 |-> &drive_hiz;
  endproperty
  a_vlow: assert property (p_vlow)
    else $error("logic supply low outputs not tristated");
  property p_vhigh;
    int'(cnt[0]) >= 6 |-> drive_on == '0 && !analog_active;
  endproperty
  a_vhigh: assert property (p_vhigh)
    else $error("logic supply high not held in reset");
  c_wake: cover property ($fell(chip_sel_n));
  c_ov: cover property (int'(cnt[5]) >= HOLD);
  c_stby: cover property ($fell(analog_active));
endmodule : sup_checker
`default_nettype wire

/* File: bench/standby_wake_fault_supervisor_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module standby_wake_fault_supervisor_tb_top;
  import sup_pkg::*;
  // short filter keeps the run brief; the fault hold waits scale from it
  localparam int FLT = 4;
  localparam logic [23:0] ACT = 24'h1 << ST_ACTIVE;
  localparam logic [23:0] M = 24'hfffff;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, seed = 32'hbfde9cf6;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic vs_over = 1'b0, vs_under = 1'b0, pump_low_in = 1'b0, temp_warn_in = 1'b0, temp_shut_in = 1'b0;
  logic vcc_low_in = 1'b0, vcc_high_in = 1'b0;
  logic [OUT_N-1:0] oc_in = '0, ol_in = '0, drive_on, drive_hiz, outs;
  logic pump_enable, mirror_dimming_control, analog_active;
  gate_e gate_mode;
  int n_errors = 0, num_checks = 0, j, k, i;
  logic [31:0] d;
  logic [63:0] mon_e;
  logic [63:0] exp_q[$];
  logic [16:0] cw;
  sup_link_if lk();
  sup_device #(.FILTER_CYC(FLT)) u_sup_device (.aclk, .aresetn, .lk(lk), .vs_over, .vs_under, .pump_low_in,
    .temp_warn_in, .temp_shut_in, .oc_in, .ol_in, .vcc_low_in, .vcc_high_in, .drive_on, .drive_hiz,
    .pump_enable, .mirror_dimming_control, .gate_mode, .analog_active);
  sup_host u_sup_host (.aclk, .aresetn, .lk(lk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sup_checker #(.FILTER_CYC(FLT)) u_sup_checker (.aclk, .aresetn, .chip_sel_n(lk.chip_sel_n),
    .link_clk(lk.link_clk), .vs_over, .vs_under, .pump_low_in, .temp_shut_in, .vcc_low_in, .vcc_high_in,
    .drive_on, .drive_hiz, .pump_enable, .mirror_dimming_control, .gate_mode, .analog_active);

  always #50 aclk = ~aclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic tmo;
    n_errors++;
    $display("BAD %0t wait ran out", $time);
    end_sim();
  endtask : tmo

  // read results are judged by the watcher below, oldest note first
  always @(posedge aclk)
  begin
    if (rvalid && rready)
    begin
      if (exp_q.size() == 0)
        tmo();
      mon_e = exp_q.pop_front();
      chk(rdata & mon_e[63:32], mon_e[31:0]);
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (n == 50)
      tmo();
    chk(bresp, er);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] q);
    int n;
    exp_q.push_back({m, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (n == 50)
      tmo();
    q = rdata;
    rready <= 1'b0;
  endtask : rd

  task automatic frame(input logic [1:0] c, input logic [23:0] e, input logic [23:0] m);
    logic [31:0] r;
    logic [OUT_N-1:0] d0;
    int n;
    d0 = drive_on;
    wr(REG_CMD, {8'h0, c, 5'h0, cw}, RESP_OKAY);
    repeat (50) @(posedge aclk);
    chk(drive_on, d0);
    for (n = 0; n < 200; n++)
    begin
      rd(REG_STATUS, 32'h0, 32'h0, r);
      if (r[STAT_BUSY] === 1'b0)
        break;
    end
    if (n == 200)
      tmo();
    rd(REG_REPLY, {8'h0, e}, {8'h0, m}, r);
  endtask : frame

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    seed = xs(seed);
    j = int'(seed[9:8]);
    k = j + 3;
    outs = seed[6:0];
    outs[j] = 1'b1;
    outs[k] = 1'b1;
    cw = {1'b1, 7'h0, outs, 1'b0, 1'b1};
    @(posedge aclk);
    chk(analog_active, 1'b0);
    wr(4'hc, xs(seed), RESP_SLVERR);
    rd(4'hc, 32'h0, 32'hffffffff, d);
    chk(rresp, RESP_SLVERR);
    frame(CMD_WRITE, 24'h0, 24'h0);
    repeat (5) @(posedge aclk);
    chk({analog_active, pump_enable, mirror_dimming_control, drive_on}, {3'b111, outs});
    oc_in[j] <= 1'b1;
    repeat (FLT + 12) @(posedge aclk);
    chk(drive_on, outs & ~(7'h1 << j));
    oc_in[j] <= 1'b0;
    repeat (20) @(posedge aclk);
    chk(drive_on, outs & ~(7'h1 << j));
    frame(CMD_READ_CLEAR, ACT | (24'h1 << (ST_OC_LSB + j)), M);
    repeat (5) @(posedge aclk);
    chk(drive_on, outs);
    vs_over <= 1'b1;
    repeat (FLT - 1) @(posedge aclk);
    vs_over <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({gate_mode, drive_hiz}, {GATE_NORMAL, 7'h0});
    cw[CTL_RD] = 1'b1;
    frame(CMD_WRITE, ACT, M);
    vs_over <= 1'b1;
    repeat (FLT + 12) @(posedge aclk);
    vs_over <= 1'b0;
    repeat (20) @(posedge aclk);
    chk(drive_on, 7'h0);
    frame(CMD_READ_CLEAR, ACT | (24'h1 << ST_OV), M);
    repeat (5) @(posedge aclk);
    chk({drive_on, drive_hiz}, {outs, 7'h0});
    cw[CTL_RD] = 1'b0;
    frame(CMD_WRITE, 24'h0, 24'h0);
    vs_under <= 1'b1;
    repeat (FLT + 12) @(posedge aclk);
    vs_under <= 1'b0;
    repeat (20) @(posedge aclk);
    chk({pump_enable, drive_on, drive_hiz}, {1'b1, outs, 7'h0});
    temp_warn_in <= 1'b1;
    ol_in[k] <= 1'b1;
    repeat (FLT + 12) @(posedge aclk);
    chk(drive_on, outs);
    temp_warn_in <= 1'b0;
    ol_in[k] <= 1'b0;
    frame(CMD_READ_CLEAR, ACT | 24'h12 | (24'h1 << (ST_OL_LSB + k)), M);
    frame(CMD_READ_CLEAR, ACT, M);
    temp_shut_in <= 1'b1;
    repeat (FLT + 12) @(posedge aclk);
    temp_shut_in <= 1'b0;
    repeat (20) @(posedge aclk);
    chk({pump_enable, drive_on}, 8'h0);
    frame(CMD_READ_CLEAR, ACT | (24'h1 << ST_TSD), M);
    pump_low_in <= 1'b1;
    repeat (FLT + 12) @(posedge aclk);
    pump_low_in <= 1'b0;
    repeat (20) @(posedge aclk);
    chk({mirror_dimming_control, drive_on}, 8'h0);
    frame(CMD_SOFT_RESET, ACT | 24'h1, M);
    frame(CMD_READ_CLEAR, ACT, M);
    for (i = 0; i < 3000; i++)
    begin
      @(posedge aclk);
      if (analog_active === 1'b0)
        break;
    end
    chk(i >= 2450 && i <= 2600, 1'b1);
    vcc_low_in <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(drive_hiz, 7'h7f);
    vcc_low_in <= 1'b0;
    vcc_high_in <= 1'b1;
    repeat (8) @(posedge aclk);
    vcc_high_in <= 1'b0;
    repeat (5) @(posedge aclk);
    chk(analog_active, 1'b0);
    frame(CMD_READ_CLEAR, 24'h0, 24'h7ffff);
    end_sim();
  end
endmodule : standby_wake_fault_supervisor_tb_top
`default_nettype wire
